// ===== pcm_command_map.sv
// Command-code register map of a step-down controller behind a packet framer.
`include "pcm_cfg.svh"

module pcm_command_map #(
   parameter int unsigned PKT_TIMEOUT_CYC = `PCM_PKT_TIMEOUT_MS * (`PCM_CLK_HZ / `PCM_MS_PER_S),
   parameter int unsigned CYC_PER_MS = `PCM_CLK_HZ / `PCM_MS_PER_S
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic frame_start_i,
   input wire pcm_pkg::pcm_req_type req_i,
   input wire logic run_pin_i,
   input wire logic [15:0] vin_l11_i,
   input wire logic [15:0] vout_l16_i,
   input wire logic [15:0] iout_l11_i,
   output pcm_pkg::pcm_rsp_type rsp_o,
   output logic busy_o,
   output logic pkt_timeout_o,
   output pcm_pkg::pcm_status_type status_o,
   output logic convert_en_o,
   output logic [15:0] vout_target_o,
   output logic [15:0] switch_freq_o,
   output logic [15:0] current_gain_o
);
   import pcm_pkg::*;

   // -------------------------------------------------------------------------
   // Decoding helpers
   // -------------------------------------------------------------------------
   localparam logic [`PCM_NSLOT-1:0][15:0] DEF = {`PCM_DEF_WORDS_HI, `PCM_DEF_WORDS_LO, `PCM_DEF_BYTES};
   localparam logic [4:0] LAST_SLOT = 5'(`PCM_NSLOT - 1);

   // Bit 5 of the result says the code names a stored setting.
   function automatic logic [5:0] slot_of(input logic [7:0] c);
      logic [5:0] r;
      r = 6'h00;
      if (c == `PCM_CMD_PAGE) r = {1'b1, `PCM_SLOT_PAGE};
      else if (c == `PCM_CMD_OPER) r = {1'b1, `PCM_SLOT_OPER};
      else if (c == `PCM_CMD_ONOFF) r = {1'b1, `PCM_SLOT_ONOFF};
      else if (c == `PCM_CMD_WPROT) r = {1'b1, `PCM_SLOT_WPROT};
      else if (c == `PCM_CMD_OVACT) r = {1'b1, `PCM_SLOT_OVACT};
      else if (c == `PCM_CMD_UVACT) r = {1'b1, `PCM_SLOT_UVACT};
      else if (c == `PCM_CMD_VNOM) r = {1'b1, `PCM_SLOT_VNOM};
      else if (c == `PCM_CMD_VMAX) r = {1'b1, `PCM_SLOT_VMAX};
      else if (c == `PCM_CMD_MHIGH) r = {1'b1, `PCM_SLOT_MHIGH};
      else if (c == `PCM_CMD_MLOW) r = {1'b1, `PCM_SLOT_MLOW};
      else if (c == `PCM_CMD_SLEW) r = {1'b1, `PCM_SLOT_SLEW};
      else if (c == `PCM_CMD_FREQ) r = {1'b1, `PCM_SLOT_FREQ};
      else if (c == `PCM_CMD_VINON) r = {1'b1, `PCM_SLOT_VINON};
      else if (c == `PCM_CMD_VINOFF) r = {1'b1, `PCM_SLOT_VINOFF};
      else if (c == `PCM_CMD_GAIN) r = {1'b1, `PCM_SLOT_GAIN};
      else if (c == `PCM_CMD_OVLIM) r = {1'b1, `PCM_SLOT_OVLIM};
      else if (c == `PCM_CMD_OVWARN) r = {1'b1, `PCM_SLOT_OVWARN};
      else if (c == `PCM_CMD_UVWARN) r = {1'b1, `PCM_SLOT_UVWARN};
      else if (c == `PCM_CMD_UVLIM) r = {1'b1, `PCM_SLOT_UVLIM};
      else if (c == `PCM_CMD_OCLIM) r = {1'b1, `PCM_SLOT_OCLIM};
      slot_of = r;
   endfunction

   function automatic logic is_word(input logic [4:0] s);
      is_word = (s >= `PCM_SLOT_FIRST_WORD);
   endfunction

   // The protection byte is a level: the highest set bit decides what stays writable.
   function automatic logic write_ok(input logic [7:0] wp, input logic [4:0] s);
      logic base;
      base = (s == `PCM_SLOT_WPROT);
      if (wp[`PCM_WP_ALL]) write_ok = base;
      else if (wp[`PCM_WP_OPER]) write_ok = base || s == `PCM_SLOT_OPER || s == `PCM_SLOT_PAGE;
      else if (wp[`PCM_WP_NOM]) write_ok = base || s == `PCM_SLOT_OPER || s == `PCM_SLOT_PAGE ||
                                          s == `PCM_SLOT_ONOFF || s == `PCM_SLOT_VNOM;
      else write_ok = 1'b1;
   endfunction

   // Linear 5/11 word as a signed value with ten fraction bits.
   function automatic logic signed [47:0] l11_val(input logic [15:0] w);
      logic signed [6:0] sh;
      logic signed [47:0] m;
      sh = {{2{w[15]}}, w[15:11]} + 7'sd10;
      m = {{37{w[10]}}, w[10:0]};
      if (sh[6]) l11_val = m >>> (-sh);
      else l11_val = m <<< sh;
   endfunction

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   pcm_core_type q;
   pcm_core_type n;
   pcm_status_type set;
   logic clr;
   logic cml;
   logic take;
   logic [5:0] hit;
   logic [4:0] slot;
   logic [7:0] op;
   logic [7:0] cfg;
   logic run_act;
   logic want_on;
   logic [15:0] sel;
   logic [15:0] tgt;
   logic [15:0] vout;
   logic signed [47:0] rate48;
   logic [31:0] rate;
   logic ov;
   logic uv;
   logic trip;

   // A request counts only inside a live packet; late or stray ones are dropped.
   assign take = req_i.valid && q.pkt_live;
   assign hit = slot_of(req_i.code);
   assign slot = hit[4:0];
   assign vout = vout_l16_i;

   always_comb
   begin
      n = q;
      set = '0;
      clr = 1'b0;
      cml = 1'b0;
      n.rsp.done = 1'b0;
      n.rsp.busy = 1'b0;
      n.rsp.fault = 1'b0;
      n.pkt_to = 1'b0;
      n.run_m = run_pin_i;
      n.run_s = q.run_m;

      // ----------------------------------------------------------------------
      // Packet timer
      // ----------------------------------------------------------------------
      if (frame_start_i)
      begin
         n.pkt_live = 1'b1;
         n.pkt_cnt = '0;
      end
      else if (q.pkt_live)
      begin
         if (q.pkt_cnt >= PKT_TIMEOUT_CYC - 1)
         begin
            n.pkt_live = 1'b0;
            n.pkt_to = 1'b1;
         end
         else
            n.pkt_cnt = q.pkt_cnt + 32'd1;
      end

      // ----------------------------------------------------------------------
      // Command execution
      // ----------------------------------------------------------------------
      if (take)
      begin
         n.pkt_live = 1'b0;
         n.pkt_to = 1'b0;
         n.rsp.done = 1'b1;
         n.rsp.rdata = 16'h0000;
         if (q.st != PCM_IDLE)
         begin
            n.rsp.busy = 1'b1;
            set.busy = 1'b1;
         end
         else if (req_i.code == `PCM_CMD_CLEAR)
         begin
            if (req_i.write && req_i.len == PCM_SEND) clr = 1'b1;
            else cml = 1'b1;
         end
         else if (req_i.code == `PCM_CMD_STORE || req_i.code == `PCM_CMD_RESTORE)
         begin
            if (req_i.write && req_i.len == PCM_SEND)
            begin
               n.st = (req_i.code == `PCM_CMD_STORE) ? PCM_STORE : PCM_RESTORE;
               n.idx = '0;
            end
            else
               cml = 1'b1;
         end
         else if (req_i.code == `PCM_CMD_CAPAB || req_i.code == `PCM_CMD_VMODE)
         begin
            if (!req_i.write && req_i.len == PCM_BYTE)
               n.rsp.rdata = (req_i.code == `PCM_CMD_CAPAB) ? `PCM_CAPAB_VALUE : `PCM_VMODE_VALUE;
            else
               cml = 1'b1;
         end
         else if (hit[5])
         begin
            if (req_i.len != (is_word(slot) ? PCM_WORD : PCM_BYTE))
               cml = 1'b1;
            else if (!req_i.write)
               n.rsp.rdata = q.regs[slot];
            else if (!write_ok(q.regs[`PCM_SLOT_WPROT][7:0], slot))
               cml = 1'b1;
            else
               n.regs[slot] = is_word(slot) ? req_i.wdata : {8'h00, req_i.wdata[7:0]};
         end
         else
            cml = 1'b1;
         if (cml)
         begin
            n.rsp.fault = 1'b1;
            set.cml = 1'b1;
         end
      end

      // ----------------------------------------------------------------------
      // Nonvolatile walker, one slot per cycle
      // ----------------------------------------------------------------------
      case (q.st)
         PCM_STORE:
         begin
            n.nonvolatile_backed[q.idx] = q.regs[q.idx];
         end
         PCM_RESTORE:
         begin
            // The page selector is volatile and keeps its value.
            if (q.idx != `PCM_SLOT_PAGE) n.regs[q.idx] = q.nonvolatile_backed[q.idx];
         end
         default:
         begin
         end
      endcase
      if (q.st != PCM_IDLE)
      begin
         if (q.idx == LAST_SLOT)
         begin
            n.st = PCM_IDLE;
            n.idx = '0;
         end
         else
            n.idx = q.idx + 5'd1;
      end

      // ----------------------------------------------------------------------
      // Conversion control
      // ----------------------------------------------------------------------
      if (l11_val(vin_l11_i) >= l11_val(q.regs[`PCM_SLOT_VINON])) n.vin_ok = 1'b1;
      else if (l11_val(vin_l11_i) <= l11_val(q.regs[`PCM_SLOT_VINOFF])) n.vin_ok = 1'b0;
      op = q.regs[`PCM_SLOT_OPER][7:0];
      cfg = q.regs[`PCM_SLOT_ONOFF][7:0];
      run_act = cfg[1] ? q.run_s : ~q.run_s;
      want_on = ~cfg[4] | ((~cfg[3] | op[7]) & (~cfg[2] | run_act));

      ov = vout > q.regs[`PCM_SLOT_OVLIM];
      uv = q.conv_en && (vout < q.regs[`PCM_SLOT_UVLIM]);
      set.ov_fault = ov;
      set.uv_fault = uv;
      set.ov_warn = vout > q.regs[`PCM_SLOT_OVWARN];
      set.uv_warn = q.conv_en && (vout < q.regs[`PCM_SLOT_UVWARN]);
      set.oc_fault = l11_val(iout_l11_i) > l11_val(q.regs[`PCM_SLOT_OCLIM]);
      trip = (ov && q.regs[`PCM_SLOT_OVACT][7:6] != 2'b00) || (uv && q.regs[`PCM_SLOT_UVACT][7:6] != 2'b00);
      // A trip beats a clear in the same cycle, so a live fault cannot slip through.
      n.latched_off = trip || (q.latched_off && !clr && want_on);
      n.conv_en = want_on && q.vin_ok && !q.latched_off;

      // Flags set by hardware survive a clear in the same cycle.
      n.status = clr ? set : (q.status | set);

      // ----------------------------------------------------------------------
      // Set point selection and slew
      // ----------------------------------------------------------------------
      if (op[5:4] == 2'b10) sel = q.regs[`PCM_SLOT_MHIGH];
      else if (op[5:4] == 2'b01) sel = q.regs[`PCM_SLOT_MLOW];
      else sel = q.regs[`PCM_SLOT_VNOM];
      tgt = (sel > q.regs[`PCM_SLOT_VMAX]) ? q.regs[`PCM_SLOT_VMAX] : sel;

      // Rate in output steps per millisecond; capped at one step per clock.
      rate48 = l11_val(q.regs[`PCM_SLOT_SLEW]) <<< 2;
      if (rate48 > $signed({16'h0000, CYC_PER_MS})) rate = CYC_PER_MS;
      else if (rate48 < 0) rate = 32'd0;
      else rate = rate48[31:0];

      if (!q.conv_en)
      begin
         n.vout_ramp = 16'h0000;
         n.slew_acc = '0;
      end
      else if (rate == 32'd0 || q.vout_ramp == tgt)
      begin
         n.vout_ramp = tgt;
         n.slew_acc = '0;
      end
      else if (q.slew_acc + rate >= CYC_PER_MS)
      begin
         n.slew_acc = q.slew_acc + rate - CYC_PER_MS;
         n.vout_ramp = (q.vout_ramp < tgt) ? q.vout_ramp + 16'd1 : q.vout_ramp - 16'd1;
      end
      else
         n.slew_acc = q.slew_acc + rate;
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         q <= '0;
         q.st <= PCM_RESTORE;
         q.regs <= DEF;
         q.nonvolatile_backed <= DEF;
      end
      else if (ce_i)
         q <= n;
   end

   // -------------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------------
   assign rsp_o = q.rsp;
   assign busy_o = (q.st != PCM_IDLE);
   assign pkt_timeout_o = q.pkt_to;
   assign status_o = q.status;
   assign convert_en_o = q.conv_en;
   assign vout_target_o = q.vout_ramp;
   assign switch_freq_o = q.regs[`PCM_SLOT_FREQ];
   assign current_gain_o = q.regs[`PCM_SLOT_GAIN];

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   a_reserved_code: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && take && q.st == PCM_IDLE && req_i.code >= `PCM_CMD_RSV_LO) |=> (q.rsp.fault && q.status.cml))
      else $error("reserved code not faulted");

   a_unsupported_code: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && take && q.st == PCM_IDLE && req_i.code == 8'h04 && req_i.write)
      |=> (q.rsp.fault && $stable(q.regs)))
      else $error("unsupported code acted on");

   a_busy_refusal: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && take && q.st != PCM_IDLE) |=> (q.rsp.busy && !q.rsp.fault && q.status.busy))
      else $error("busy request not refused");

   a_mode_exponent: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && take && q.st == PCM_IDLE && !req_i.write && req_i.len == PCM_BYTE && req_i.code == `PCM_CMD_VMODE)
      |=> (q.rsp.rdata == 16'h0014))
      else $error("mode byte wrong");

   a_protocol_feature_summary_value: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && take && q.st == PCM_IDLE && !req_i.write && req_i.len == PCM_BYTE && req_i.code == `PCM_CMD_CAPAB)
      |=> (q.rsp.rdata == 16'h00b0 && !q.rsp.fault))
      else $error("protocol_feature_summary byte wrong");

   a_clear_faults: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && clr && set == '0) |=> (q.status == '0))
      else $error("faults not cleared");

   a_store_copy: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && q.st == PCM_STORE && q.idx == LAST_SLOT) |=> (q.nonvolatile_backed == $past(q.regs) && q.st == PCM_IDLE))
      else $error("store did not copy settings");

   a_protect_block: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && take && q.st == PCM_IDLE && req_i.write && req_i.code == `PCM_CMD_VNOM && req_i.len == PCM_WORD &&
       q.regs[`PCM_SLOT_WPROT][`PCM_WP_ALL]) |=> (q.rsp.fault && $stable(q.regs[`PCM_SLOT_VNOM])))
      else $error("protected write accepted");

   a_slew_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && q.conv_en && n.conv_en) |=>
      ($stable(q.vout_ramp) ||
       q.vout_ramp == $past(q.vout_ramp) - 16'd1 || q.vout_ramp == $past(q.vout_ramp) + 16'd1 ||
       q.vout_ramp == $past(tgt)))
      else $error("output moved faster than one step");

   a_vin_turn_on: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && l11_val(vin_l11_i) >= l11_val(q.regs[`PCM_SLOT_VINON])) |=> q.vin_ok)
      else $error("input threshold ignored");

   a_ov_shutdown: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && ov && q.regs[`PCM_SLOT_OVACT][7:6] != 2'b00) ##1 ce_i |=> !q.conv_en)
      else $error("overvoltage did not shut down");

   a_timeout_drop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && q.pkt_to) |-> (!q.pkt_live && !q.rsp.done))
      else $error("timed out packet still live");
endmodule

// ===== pcm_cfg.svh
// Command codes, slot layout, reset values and timing counts of the command map.
`ifndef PCM_CFG_SVH
`define PCM_CFG_SVH

// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define PCM_CMD_PAGE 8'h00
`define PCM_CMD_OPER 8'h01
`define PCM_CMD_ONOFF 8'h02
`define PCM_CMD_CLEAR 8'h03
`define PCM_CMD_WPROT 8'h10
`define PCM_CMD_STORE 8'h15
`define PCM_CMD_RESTORE 8'h16
`define PCM_CMD_CAPAB 8'h19
`define PCM_CMD_VMODE 8'h20
`define PCM_CMD_VNOM 8'h21
`define PCM_CMD_VMAX 8'h24
`define PCM_CMD_MHIGH 8'h25
`define PCM_CMD_MLOW 8'h26
`define PCM_CMD_SLEW 8'h27
`define PCM_CMD_FREQ 8'h33
`define PCM_CMD_VINON 8'h35
`define PCM_CMD_VINOFF 8'h36
`define PCM_CMD_GAIN 8'h38
`define PCM_CMD_OVLIM 8'h40
`define PCM_CMD_OVACT 8'h41
`define PCM_CMD_OVWARN 8'h42
`define PCM_CMD_UVWARN 8'h43
`define PCM_CMD_UVLIM 8'h44
`define PCM_CMD_UVACT 8'h45
`define PCM_CMD_OCLIM 8'h46
`define PCM_CMD_RSV_LO 8'hd0

// ----------------------------------------------------------------------------
// Storage slots: byte registers first, words from PCM_SLOT_FIRST_WORD upward
// ----------------------------------------------------------------------------
`define PCM_NSLOT 20
`define PCM_SLOT_PAGE 5'd0
`define PCM_SLOT_OPER 5'd1
`define PCM_SLOT_ONOFF 5'd2
`define PCM_SLOT_WPROT 5'd3
`define PCM_SLOT_OVACT 5'd4
`define PCM_SLOT_UVACT 5'd5
`define PCM_SLOT_VNOM 5'd6
`define PCM_SLOT_VMAX 5'd7
`define PCM_SLOT_MHIGH 5'd8
`define PCM_SLOT_MLOW 5'd9
`define PCM_SLOT_SLEW 5'd10
`define PCM_SLOT_FREQ 5'd11
`define PCM_SLOT_VINON 5'd12
`define PCM_SLOT_VINOFF 5'd13
`define PCM_SLOT_GAIN 5'd14
`define PCM_SLOT_OVLIM 5'd15
`define PCM_SLOT_OVWARN 5'd16
`define PCM_SLOT_UVWARN 5'd17
`define PCM_SLOT_UVLIM 5'd18
`define PCM_SLOT_OCLIM 5'd19
`define PCM_SLOT_FIRST_WORD 5'd6

// ----------------------------------------------------------------------------
// Reset values and fixed read values
// ----------------------------------------------------------------------------
`define PCM_DEF_BYTES {16'h00b8, 16'h00b8, 16'h0000, 16'h001e, 16'h0080, 16'h0000}
`define PCM_DEF_WORDS_LO {16'hbb9a, 16'hcb00, 16'hcb40, 16'hfabc, 16'haa00, 16'h0f33, 16'h10cd, 16'h5800, 16'h1000}
`define PCM_DEF_WORDS_HI {16'hdbb8, 16'h0e66, 16'h0ecd, 16'h1133, 16'h119a}
`define PCM_CAPAB_VALUE 16'h00b0
`define PCM_VMODE_VALUE 16'h0014

// ----------------------------------------------------------------------------
// Protection levels and timing
// ----------------------------------------------------------------------------
`define PCM_WP_ALL 7
`define PCM_WP_OPER 6
`define PCM_WP_NOM 5
`define PCM_CLK_HZ 25000000
`define PCM_MS_PER_S 1000
`define PCM_PKT_TIMEOUT_MS 20

`endif

// ===== pcm_pkg.sv
// Types shared by the command map and its neighbours.
package pcm_pkg;
`include "pcm_cfg.svh"

   typedef enum logic [1:0] {PCM_SEND = 2'b00, PCM_BYTE = 2'b01, PCM_WORD = 2'b10} pcm_len_type;

   typedef struct packed {
      logic valid;
      logic write;
      pcm_len_type len;
      logic [7:0] code;
      logic [15:0] wdata;
   } pcm_req_type;

   typedef struct packed {
      logic done;
      logic busy;
      logic fault;
      logic [15:0] rdata;
   } pcm_rsp_type;

   typedef struct packed {
      logic cml;
      logic busy;
      logic ov_fault;
      logic ov_warn;
      logic uv_warn;
      logic uv_fault;
      logic oc_fault;
   } pcm_status_type;

   typedef enum logic [2:0] {PCM_IDLE = 3'b001, PCM_STORE = 3'b010, PCM_RESTORE = 3'b100} pcm_state_type;

   typedef struct packed {
      pcm_state_type st;
      logic [4:0] idx;
      logic [`PCM_NSLOT-1:0][15:0] regs;
      logic [`PCM_NSLOT-1:0][15:0] nonvolatile_backed;
      pcm_status_type status;
      pcm_rsp_type rsp;
      logic run_m;
      logic run_s;
      logic vin_ok;
      logic latched_off;
      logic conv_en;
      logic [15:0] vout_ramp;
      logic [31:0] slew_acc;
      logic [31:0] pkt_cnt;
      logic pkt_live;
      logic pkt_to;
   } pcm_core_type;
endpackage

// ===== pcm_host_model.sv
// Host-side model that frames one command per packet.
module pcm_host_model (
   input wire logic clk_i,
   input wire pcm_pkg::pcm_rsp_type rsp_i,
   output logic frame_start_o,
   output pcm_pkg::pcm_req_type req_o
);
   timeunit 1ns;
   timeprecision 1ns;
   import pcm_pkg::*;
   // Margins are left at their defaults and nominal writes stay between them.
   initial
   begin
      frame_start_o = 1'b0;
      req_o = '0;
   end
   task automatic open_only();
      @(posedge clk_i);
      frame_start_o <= 1'b1;
      @(posedge clk_i);
      frame_start_o <= 1'b0;
   endtask
   // The request follows the frame by one edge, far inside the packet window.
   task automatic xfer(input logic wr, input pcm_len_type len, input logic [7:0] code,
      input logic [15:0] wd, output logic [15:0] rd, output logic [2:0] flg);
      int n;
      open_only();
      req_o <= '{1'b1, wr, len, code, wd};
      @(posedge clk_i);
      req_o.valid <= 1'b0;
      flg = 3'b000;
      rd = 16'h0000;
      for (n = 0; n < 4 && flg[2] !== 1'b1; n++)
      begin
         #1;
         flg = {rsp_i.done, rsp_i.busy, rsp_i.fault};
         rd = rsp_i.rdata;
         if (flg[2] !== 1'b1)
            @(posedge clk_i);
      end
   endtask
endmodule

// ===== tb.sv
// Self-checking bench for the command map.
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import pcm_pkg::*;
   localparam int unsigned PKT = 50;
   logic clk_i;
   logic rst_n_i;
   logic ce_i;
   logic run_pin_i;
   logic [15:0] vin_l11_i;
   logic [15:0] vout_l16_i;
   logic frame_start_i;
   pcm_req_type req_i;
   pcm_rsp_type rsp_o;
   logic busy_o;
   logic pkt_timeout_o;
   pcm_status_type status_o;
   logic convert_en_o;
   logic [15:0] vout_target_o;
   logic [15:0] switch_freq_o;
   logic [15:0] current_gain_o;
   logic [15:0] rd;
   logic [2:0] flg;
   int error_cnt;
   int compares;
   int n;
   logic [23:0] dflt [22] = '{24'h01_0080, 24'h02_001e, 24'h10_0000, 24'h19_00b0, 24'h20_0014,
      24'h21_1000, 24'h24_5800, 24'h25_10cd, 24'h26_0f33, 24'h27_aa00, 24'h33_fabc, 24'h35_cb40,
      24'h36_cb00, 24'h38_bb9a, 24'h40_119a, 24'h41_00b8, 24'h42_1133, 24'h43_0ecd, 24'h44_0e66,
      24'h45_00b8, 24'h46_dbb8, 24'h00_0000};
   logic [7:0] bad [3] = '{8'h04, 8'hd0, 8'hff};
   pcm_command_map #(.PKT_TIMEOUT_CYC(PKT), .CYC_PER_MS(100)) pcm_command_map_i (.clk_i, .rst_n_i,
      .ce_i, .frame_start_i, .req_i, .run_pin_i, .vin_l11_i, .vout_l16_i, .iout_l11_i(16'h0000),
      .rsp_o, .busy_o, .pkt_timeout_o, .status_o, .convert_en_o, .vout_target_o, .switch_freq_o,
      .current_gain_o);
   pcm_host_model pcm_host_model_i (.clk_i, .rsp_i(rsp_o), .frame_start_o(frame_start_i), .req_o(req_i));
   // ----------------------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------------------
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cmd(input logic wr, input pcm_len_type len, input logic [7:0] code, input logic [15:0] wd);
      pcm_host_model_i.xfer(wr, len, code, wd, rd, flg);
      if (flg[2] !== 1'b1)
      begin
         chk("done", 16'(flg[2]), 16'h0001);
         print_verdict();
      end
   endtask
   task automatic settle(input int cyc);
      repeat (cyc) @(posedge clk_i);
      #1;
   endtask
   task automatic wait_idle();
      for (n = 0; n < 40 && busy_o !== 1'b0; n++)
         settle(1);
      if (busy_o !== 1'b0)
      begin
         chk("busy_o", 16'(busy_o), 16'h0000);
         print_verdict();
      end
   endtask
   initial
   begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   // ----------------------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------------------
   initial
   begin
      rst_n_i = 1'b0;
      ce_i = 1'b1;
      run_pin_i = 1'b1;
      vin_l11_i = 16'hcb40;
      vout_l16_i = 16'h1000;
      error_cnt = 0;
      compares = 0;
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      settle(0);
      chk("freq", switch_freq_o, 16'hfabc);
      chk("gain", current_gain_o, 16'hbb9a);
      cmd(1'b0, PCM_BYTE, 8'h01, 16'h0000);
      chk("busy", 16'(flg[1]), 16'h0001);
      wait_idle();
      foreach (dflt[i])
      begin
         cmd(1'b0, dflt[i][15:0] > 16'h00ff ? PCM_WORD : PCM_BYTE, dflt[i][23:16], 16'h0000);
         chk("default", rd, dflt[i][15:0]);
      end
      foreach (bad[i])
      begin
         cmd(i == 0, PCM_BYTE, bad[i], 16'h0000);
         chk("bad fault", 16'(flg[0]), 16'h0001);
      end
      cmd(1'b1, PCM_BYTE, 8'h19, 16'h0055);
      chk("ro fault", 16'(flg[0]), 16'h0001);
      cmd(1'b1, PCM_SEND, 8'h03, 16'h0000);
      chk("status", 16'(status_o), 16'h0000);
      cmd(1'b1, PCM_BYTE, 8'h10, 16'h0080);
      cmd(1'b1, PCM_WORD, 8'h21, 16'h1040);
      chk("prot fault", 16'(flg[0]), 16'h0001);
      cmd(1'b1, PCM_BYTE, 8'h10, 16'h0000);
      cmd(1'b1, PCM_WORD, 8'h21, 16'h1080);
      cmd(1'b1, PCM_SEND, 8'h15, 16'h0000);
      chk("store busy", 16'(busy_o), 16'h0001);
      wait_idle();
      cmd(1'b1, PCM_WORD, 8'h21, 16'h1000);
      cmd(1'b1, PCM_SEND, 8'h16, 16'h0000);
      wait_idle();
      cmd(1'b0, PCM_WORD, 8'h21, 16'h0000);
      chk("restored", rd, 16'h1080);
      cmd(1'b1, PCM_WORD, 8'h27, 16'h0000);
      cmd(1'b1, PCM_WORD, 8'h24, 16'h0f00);
      settle(8);
      chk("conv", 16'(convert_en_o), 16'h0001);
      chk("capped", vout_target_o, 16'h0f00);
      cmd(1'b1, PCM_WORD, 8'h24, 16'h5800);
      cmd(1'b1, PCM_BYTE, 8'h01, 16'h00a0);
      settle(8);
      chk("margin hi", vout_target_o, 16'h10cd);
      vout_l16_i <= 16'h1140;
      settle(8);
      chk("ov warn", 16'(status_o.ov_warn), 16'h0001);
      vout_l16_i <= 16'h1200;
      settle(8);
      chk("ov off", 16'(convert_en_o), 16'h0000);
      vout_l16_i <= 16'h1000;
      vin_l11_i <= 16'hcb00;
      cmd(1'b1, PCM_SEND, 8'h03, 16'h0000);
      settle(8);
      chk("input_turn_off_threshold", 16'(convert_en_o), 16'h0000);
      vin_l11_i <= 16'hcb40;
      settle(8);
      chk("back on", 16'(convert_en_o), 16'h0001);
      vout_l16_i <= 16'h0e00;
      settle(8);
      chk("uv off", 16'(convert_en_o), 16'h0000);
      // Five frozen cycles must not count toward the packet window.
      pcm_host_model_i.open_only();
      ce_i <= 1'b0;
      settle(5);
      ce_i <= 1'b1;
      for (n = 0; n < PKT + 5 && pkt_timeout_o !== 1'b1; n++)
         settle(1);
      chk("timeout", 16'(n), 16'(PKT));
      print_verdict();
   end
endmodule
